// *** shared/att_pkg.sv ***
// Purpose: Constants and types for the converter threshold and trigger register block.
// Assumes: 32-bit AHB-Lite data, one aligned word per register, data in the low byte.
// Notes:
// Notes on behaviour
// - Error reads as signed high/low bytes.
// - Error computed per calculation-select field.
// - Lower threshold writable, signed, resets zero.
// - Upper threshold writable, signed, resets zero.
// - Threshold compare sets upper/lower status flags.
// - Threshold interrupt only for selected mode.
// - Trigger select five bits, upper bits zero.
// - Code zero off, code one pin.
// - Timer, measurement and capture codes mapped.
// - PWM, oscillator, comparator, pin-change, logic codes.
// - Software read/write codes start conversions.
// - Pump on only when enabled and requested.
// - Pump ready flag read-only, bit zero.
// - Pump control bits six-one read zero.
// - Setpoint may be an error operand.
package att_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFF_ERR_HI  = 8'h00;
  localparam logic [7:0] OFF_ERR_LO  = 8'h04;
  localparam logic [7:0] OFF_LTH_HI  = 8'h08;
  localparam logic [7:0] OFF_LTH_LO  = 8'h0C;
  localparam logic [7:0] OFF_UTH_HI  = 8'h10;
  localparam logic [7:0] OFF_UTH_LO  = 8'h14;
  localparam logic [7:0] OFF_ACT     = 8'h18;
  localparam logic [7:0] OFF_CP      = 8'h1C;
  localparam logic [7:0] OFF_CFG3    = 8'h20;
  localparam logic [7:0] OFF_THRESHOLD_SETPOINT_HI = 8'h24;
  localparam logic [7:0] OFF_THRESHOLD_SETPOINT_LO = 8'h28;
  localparam logic [7:0] OFF_STAT    = 8'h2C;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h30;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h34;
  localparam logic [7:0] OFF_RES_HI  = 8'h38;
  localparam logic [7:0] OFF_CHAN    = 8'h3C;

  // ==========================================================================
  // Field positions and reset values.
  localparam int          CP_EN_BIT   = 7;
  localparam int          CP_RDY_BIT  = 0;
  localparam int          STAT_UP_BIT = 6;
  localparam int          STAT_LO_BIT = 5;
  localparam int          IRQ_THR_BIT = 0;
  localparam int          IRQ_RDY_BIT = 1;
  localparam int          IRQ_W       = 2;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;

  // ==========================================================================
  // Trigger selector codes.
  localparam logic [4:0] ACT_OFF      = 5'h00;
  localparam logic [4:0] ACT_LAST_HW  = 5'h19;
  localparam logic [4:0] ACT_RD_ERR   = 5'h1A;
  localparam logic [4:0] ACT_RD_RES   = 5'h1B;
  localparam logic [4:0] ACT_WR_CHAN  = 5'h1D;

  typedef enum logic [2:0] {
    TMD_NEVER, TMD_BELOW, TMD_NOT_BELOW, TMD_INSIDE,
    TMD_OUTSIDE, TMD_NOT_ABOVE, TMD_ABOVE, TMD_ALWAYS
  } att_tmd_e;

  typedef enum logic [2:0] {
    ERROR_SELECT_A_RES_MINUS_THRESHOLD_SETPOINT, ERROR_SELECT_A_THRESHOLD_SETPOINT_MINUS_RES, ERROR_SELECT_A_RES_RAW, ERROR_SELECT_A_RSV3,
    ERROR_SELECT_A_RSV4, ERROR_SELECT_A_RSV5, ERROR_SELECT_A_RSV6, ERROR_SELECT_A_RSV7
  } att_error_select_a_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       read;
  } att_acc_s;

endpackage : att_pkg

// *** rtl/att_top.sv ***
// Purpose: Setpoint error, thresholds, auto-trigger select and pump control registers.
// Assumes: Single-clock AHB-Lite slave; trigger pins and pump ready are asynchronous.
// Notes: Zero wait states; read data is registered in the address phase.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

module att_top
  import att_pkg::*;
#(
  parameter int TRIG_W = 25
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [15:0]       convResult,
  input  wire logic              convDone,
  input  wire logic [TRIG_W:1]   trigIn,
  input  wire logic              pumpRequest,
  input  wire logic              pumpReadyIn,
  output logic                   convStart,
  output logic                   pumpOn,
  output logic                   irq
);

  // ==========================================================================
  // Elaboration check: one input per hardware selector code.
  if (TRIG_W != int'(ACT_LAST_HW)) begin : g_bad_width
    $error("TRIG_W must equal the number of hardware trigger codes.");
  end

  // ==========================================================================
  // Register state.
  logic signed [15:0] setpointError;
  logic signed [15:0] lowerThreshold;
  logic signed [15:0] upperThreshold;
  logic signed [15:0] thresholdSetpoint;
  logic [4:0]         triggerSelectField;
  logic               pumpEnable;
  logic               pumpReadyFlag;
  logic [2:0]         errorSelectA;
  logic [2:0]         thresholdInterruptMode;
  logic               upperThresholdFlag;
  logic               lowerThresholdFlag;
  logic [IRQ_W-1:0]   irqStatus;
  logic [IRQ_W-1:0]   irqMask;
  logic [5:0]         channelSelect;
  att_acc_s           dataPhase;

  // ==========================================================================
  // Synchronisers for pins from outside the clock domain.
  logic [TRIG_W:1] trigMeta;
  logic [TRIG_W:1] trigSync;
  logic [TRIG_W:1] trigLast;
  logic            readyMeta;
  logic            readySync;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trigMeta  <= '0;
      trigSync  <= '0;
      trigLast  <= '0;
      readyMeta <= 1'b0;
      readySync <= 1'b0;
    end else begin
      trigMeta  <= trigIn;
      trigSync  <= trigMeta;
      trigLast  <= trigSync;
      readyMeta <= pumpReadyIn;
      readySync <= readyMeta;
    end
  end

  // ==========================================================================
  // AHB-Lite address phase decode.
  logic addrTaken;
  logic rdTaken;
  logic wrNow;
  logic [7:0] wrByte;
  logic [7:0] rdAddr;

  assign addrTaken = hsel & htrans[1] & hready;
  assign rdTaken   = addrTaken & ~hwrite;
  assign rdAddr    = haddr[7:0];
  assign wrNow     = dataPhase.write;
  assign wrByte    = hwdata[7:0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dataPhase <= '0;
    end else begin
      dataPhase.addr  <= haddr[7:0];
      dataPhase.write <= addrTaken & hwrite;
      dataPhase.read  <= rdTaken;
    end
  end

  // Zero wait states and an OKAY answer keep the slave simple.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================================
  // Read mux, registered so that hrdata comes from a flip-flop.
  logic [7:0] next_rdByte;

  always_comb begin
    next_rdByte = RST_BYTE;
    unique case (rdAddr)
      OFF_ERR_HI:  next_rdByte = setpointError[15:8];
      OFF_ERR_LO:  next_rdByte = setpointError[7:0];
      OFF_LTH_HI:  next_rdByte = lowerThreshold[15:8];
      OFF_LTH_LO:  next_rdByte = lowerThreshold[7:0];
      OFF_UTH_HI:  next_rdByte = upperThreshold[15:8];
      OFF_UTH_LO:  next_rdByte = upperThreshold[7:0];
      OFF_ACT:     next_rdByte = {3'h0, triggerSelectField};
      OFF_CP:      next_rdByte = {pumpEnable, 6'h00, pumpReadyFlag};
      OFF_CFG3:    next_rdByte = {1'b0, errorSelectA, 1'b0, thresholdInterruptMode};
      OFF_THRESHOLD_SETPOINT_HI: next_rdByte = thresholdSetpoint[15:8];
      OFF_THRESHOLD_SETPOINT_LO: next_rdByte = thresholdSetpoint[7:0];
      OFF_STAT:    next_rdByte = {1'b0, upperThresholdFlag, lowerThresholdFlag, 5'h00};
      OFF_IRQ_ST:  next_rdByte = {6'h00, irqStatus};
      OFF_IRQ_MSK: next_rdByte = {6'h00, irqMask};
      OFF_RES_HI:  next_rdByte = convResult[15:8];
      OFF_CHAN:    next_rdByte = {2'h0, channelSelect};
      default:     next_rdByte = RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= '0;
    end else if (rdTaken) begin
      hrdata <= {24'h000000, next_rdByte};
    end
  end

  // ==========================================================================
  // Writable configuration.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lowerThreshold <= RST_WORD;
      upperThreshold <= RST_WORD;
    end else if (wrNow) begin
      if (dataPhase.addr == OFF_LTH_HI) lowerThreshold[15:8] <= wrByte;
      if (dataPhase.addr == OFF_LTH_LO) lowerThreshold[7:0]  <= wrByte;
      if (dataPhase.addr == OFF_UTH_HI) upperThreshold[15:8] <= wrByte;
      if (dataPhase.addr == OFF_UTH_LO) upperThreshold[7:0]  <= wrByte;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      thresholdSetpoint      <= RST_WORD;
      errorSelectA           <= 3'h0;
      thresholdInterruptMode <= 3'h0;
      channelSelect          <= 6'h00;
      irqMask                <= '0;
    end else if (wrNow) begin
      if (dataPhase.addr == OFF_THRESHOLD_SETPOINT_HI) thresholdSetpoint[15:8] <= wrByte;
      if (dataPhase.addr == OFF_THRESHOLD_SETPOINT_LO) thresholdSetpoint[7:0]  <= wrByte;
      if (dataPhase.addr == OFF_CFG3) begin
        errorSelectA           <= wrByte[6:4];
        thresholdInterruptMode <= wrByte[2:0];
      end
      if (dataPhase.addr == OFF_CHAN)    channelSelect <= wrByte[5:0];
      if (dataPhase.addr == OFF_IRQ_MSK) irqMask       <= wrByte[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      triggerSelectField <= ACT_OFF;
      pumpEnable         <= 1'b0;
    end else if (wrNow) begin
      if (dataPhase.addr == OFF_ACT) triggerSelectField <= wrByte[4:0];
      if (dataPhase.addr == OFF_CP)  pumpEnable <= wrByte[CP_EN_BIT];
    end
  end

  // ==========================================================================
  // Setpoint error; it is left without reset so it powers up unknown.
  logic signed [15:0] next_error;
  logic signed [15:0] resultSigned;

  assign resultSigned = signed'(convResult);

  always_comb begin
    unique case (att_error_select_a_e'(errorSelectA))
      ERROR_SELECT_A_RES_MINUS_THRESHOLD_SETPOINT: next_error = resultSigned - thresholdSetpoint;
      ERROR_SELECT_A_THRESHOLD_SETPOINT_MINUS_RES: next_error = thresholdSetpoint - resultSigned;
      default:             next_error = resultSigned;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (convDone) begin
      setpointError <= next_error;
    end
  end

  // ==========================================================================
  // Threshold comparison on each finished conversion.
  logic isAbove;
  logic isBelow;
  logic thrHit;

  assign isAbove = next_error > upperThreshold;
  assign isBelow = next_error < lowerThreshold;

  always_comb begin
    unique case (att_tmd_e'(thresholdInterruptMode))
      TMD_NEVER:     thrHit = 1'b0;
      TMD_BELOW:     thrHit = isBelow;
      TMD_NOT_BELOW: thrHit = ~isBelow;
      TMD_INSIDE:    thrHit = ~isBelow & ~isAbove;
      TMD_OUTSIDE:   thrHit = isBelow | isAbove;
      TMD_NOT_ABOVE: thrHit = ~isAbove;
      TMD_ABOVE:     thrHit = isAbove;
      TMD_ALWAYS:    thrHit = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      upperThresholdFlag <= 1'b0;
      lowerThresholdFlag <= 1'b0;
    end else if (convDone) begin
      upperThresholdFlag <= isAbove;
      lowerThresholdFlag <= isBelow;
    end
  end

  // ==========================================================================
  // Charge pump: the ready flag only shows while the pump is enabled.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pumpOn        <= 1'b0;
      pumpReadyFlag <= 1'b0;
    end else begin
      pumpOn        <= pumpEnable & pumpRequest;
      pumpReadyFlag <= pumpEnable & readySync;
    end
  end

  // ==========================================================================
  // Interrupt status, write one to clear; a new event wins over the clear.
  logic [IRQ_W-1:0] irqEvent;
  logic [IRQ_W-1:0] irqClear;
  logic             readyRise;

  assign readyRise = pumpEnable & readySync & ~pumpReadyFlag;
  assign irqEvent  = {readyRise, convDone & thrHit};
  assign irqClear  = (wrNow && dataPhase.addr == OFF_IRQ_ST) ? wrByte[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= '0;
      irq       <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvent;
      irq       <= |(((irqStatus & ~irqClear) | irqEvent) & irqMask);
    end
  end

  // ==========================================================================
  // Auto-conversion trigger select. Hardware sources start on a rising edge.
  logic [TRIG_W:1] trigRise;
  logic            hwTrig;
  logic            swTrig;

  assign trigRise = trigSync & ~trigLast;

  always_comb begin
    hwTrig = 1'b0;
    if (triggerSelectField != ACT_OFF && triggerSelectField <= ACT_LAST_HW) begin
      hwTrig = trigRise[triggerSelectField];
    end
  end

  always_comb begin
    unique case (triggerSelectField)
      ACT_RD_ERR:  swTrig = rdTaken && rdAddr == OFF_ERR_HI;
      ACT_RD_RES:  swTrig = rdTaken && rdAddr == OFF_RES_HI;
      ACT_WR_CHAN: swTrig = wrNow && dataPhase.addr == OFF_CHAN;
      default:     swTrig = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      convStart <= 1'b0;
    end else begin
      convStart <= hwTrig | swTrig;
    end
  end

endmodule : att_top

// *** sim/att_checker.sv ***
// Purpose: Port-level assertions for the threshold and trigger register block.
// Assumes: Zero-wait slave; a write lands at the edge that ends its data phase.
// Notes: Helper logic shadows trigger code, mask and pump enable from bus writes.
`timescale 1ns/1ps

module att_checker
  import att_pkg::*;
#(
  parameter int TRIG_W = 25
) (
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [15:0]       convResult,
  input wire logic              convDone,
  input wire logic [TRIG_W:1]   trigIn,
  input wire logic              pumpRequest,
  input wire logic              pumpReadyIn,
  input wire logic              convStart,
  input wire logic              pumpOn,
  input wire logic              irq
);
  // ==========================================================================
  // Shadow state.
  logic       addrOk;
  logic       wrPend;
  logic [7:0] wrAddr;
  logic [4:0] actCode;
  logic       mskZero;
  logic       cpEn;
  logic [3:0] offCnt;
  assign addrOk = hsel && htrans[1] && hready;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else if (hready) begin
      wrPend <= addrOk && hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      actCode <= ACT_OFF;
      mskZero <= 1'b1;
      cpEn    <= 1'b0;
    end else if (wrPend && hready) begin
      if (wrAddr == OFF_ACT) actCode <= hwdata[4:0];
      if (wrAddr == OFF_IRQ_MSK) mskZero <= (hwdata[IRQ_W-1:0] == '0);
      if (wrAddr == OFF_CP) cpEn <= hwdata[CP_EN_BIT];
    end
  end

  // A trigger already in the synchroniser may still fire, so wait eight cycles.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) offCnt <= 4'h0;
    else if (!(actCode inside {ACT_OFF, 5'h1C, 5'h1E, 5'h1F})) offCnt <= 4'h0;
    else if (offCnt != 4'h8) offCnt <= offCnt + 4'h1;
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  ready_always_a: assert property (hreadyout)
    else $error("slave stalled the bus");
  resp_okay_a: assert property (!hresp)
    else $error("slave gave an error response");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above the low byte");
  act_read_a: assert property (addrOk && !hwrite && haddr[7:0] == OFF_ACT
    |=> hrdata[7:5] == 3'h0) else $error("trigger select top bits set");
  cp_read_a: assert property (addrOk && !hwrite && haddr[7:0] == OFF_CP
    |=> hrdata[6:1] == 6'h00) else $error("pump control spare bits set");
  pump_gate_a: assert property (!pumpRequest || !cpEn |=> !pumpOn)
    else $error("pump on without enable and request");
  quiet_trig_a: assert property (offCnt == 4'h8 |-> !convStart)
    else $error("start while triggering is off");
  sw_read_a: assert property (actCode == ACT_RD_ERR && addrOk && !hwrite
    && haddr[7:0] == OFF_ERR_HI |=> convStart) else $error("no start on error read");
  mask_off_a: assert property (mskZero && $past(mskZero) |-> !irq)
    else $error("interrupt with all sources masked");
endmodule : att_checker

bind att_top att_checker #(.TRIG_W(TRIG_W)) chk (
  .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .convResult(convResult), .convDone(convDone),
  .trigIn(trigIn), .pumpRequest(pumpRequest), .pumpReadyIn(pumpReadyIn),
  .convStart(convStart), .pumpOn(pumpOn), .irq(irq));

// *** sim/test_att_top.sv ***
// Purpose: Self-checking bench for the threshold and trigger register block.
// Assumes: Zero-wait AHB-Lite slave driving its own hready.
// Notes: Random thresholds and results from a fixed seed, boundaries among them.
`timescale 1ns/1ps

module test_att_top
  import att_pkg::*;
;
  logic        sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0, convDone = 0;
  logic        pumpRequest = 0, pumpReadyIn = 0, msk, h;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q, x;
  logic [1:0]  htrans = '0;
  logic [15:0] convResult = '0, l, u, sp, r, e;
  logic [25:1] trigIn = '0;
  logic [2:0]  error_select_a, m;
  logic        hreadyout, hresp, convStart, pumpOn, irq;
  logic [7:0]  rstList[7] = '{OFF_LTH_HI, OFF_LTH_LO, OFF_UTH_HI, OFF_UTH_LO,
                              OFF_ACT, OFF_CP, 8'h40};
  logic [4:0]  swCode[3] = '{ACT_RD_ERR, ACT_RD_RES, ACT_WR_CHAN};
  int          bad_count = 0, tests_run = 0, seed = 97969, starts = 0;
  int          i, c, k, j, s0;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (convStart === 1'b1) starts++;

  att_top #(.TRIG_W(25)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .convResult(convResult),
    .convDone(convDone), .trigIn(trigIn), .pumpRequest(pumpRequest),
    .pumpReadyIn(pumpReadyIn), .convStart(convStart), .pumpOn(pumpOn), .irq(irq));

  // ==========================================================================
  // Bus and check tasks.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    tests_run++;
    if (s !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, s);
      bad_count++;
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) bad_count++;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (hreadyout !== 1'b1) bad_count++;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] t;
    bus(a, 1'b1, d, t);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] ex, input string nm);
    logic [31:0] t;
    bus(a, 1'b0, 8'h00, t);
    chk(nm, {24'h0, ex}, t);
  endtask : rc

  function automatic logic [15:0] expErr(input logic [2:0] cs, input logic [15:0] rr, ss);
    case (cs)
      3'h0: expErr = rr - ss;
      3'h1: expErr = ss - rr;
      default: expErr = rr;
    endcase
  endfunction : expErr

  function automatic logic hit(input logic [2:0] md, input logic signed [15:0] ev, lv, uv);
    case (md)
      3'h0: hit = 1'b0;
      3'h1: hit = ev < lv;
      3'h2: hit = ev >= lv;
      3'h3: hit = ev >= lv && ev <= uv;
      3'h4: hit = ev < lv || ev > uv;
      3'h5: hit = ev <= uv;
      3'h6: hit = ev > uv;
      default: hit = 1'b1;
    endcase
  endfunction : hit

  // ==========================================================================
  // Sequence.
  initial begin
    #1_000_000;
    bad_count++;
    end_of_test;
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    foreach (rstList[k]) rc(rstList[k], RST_BYTE, "resetValue");
    wr(OFF_ACT, 8'hF9);
    rc(OFF_ACT, 8'h19, "triggerSelect");
    wr(OFF_CP, 8'h7F);
    rc(OFF_CP, 8'h00, "pumpControl");
    wr(OFF_ACT, 8'h00);
    // The first eight passes put the error exactly on the lower threshold.
    for (i = 0; i < 24; i++) begin
      x = $random(seed);
      l = x[15:0];
      u = x[31:16];
      x = $random(seed);
      sp = x[15:0];
      r = x[31:16];
      x = $random(seed);
      error_select_a = {1'b0, x[1:0]};
      msk = x[2];
      if (i < 8) begin
        error_select_a = 3'h0;
        r = sp + l;
      end
      m = i[2:0];
      wr(OFF_CFG3, {1'b0, error_select_a, 1'b0, m});
      wr(OFF_LTH_HI, l[15:8]);
      wr(OFF_LTH_LO, l[7:0]);
      wr(OFF_UTH_HI, u[15:8]);
      wr(OFF_UTH_LO, u[7:0]);
      wr(OFF_THRESHOLD_SETPOINT_HI, sp[15:8]);
      wr(OFF_THRESHOLD_SETPOINT_LO, sp[7:0]);
      wr(OFF_IRQ_MSK, {7'h0, msk});
      rc(OFF_LTH_LO, l[7:0], "lowerLow");
      rc(OFF_UTH_HI, u[15:8], "upperHigh");
      rc(OFF_THRESHOLD_SETPOINT_HI, sp[15:8], "setpointHigh");
      rc(OFF_CFG3, {1'b0, error_select_a, 1'b0, m}, "config3");
      convResult <= r;
      convDone <= 1'b1;
      @(posedge sys_clk);
      convDone <= 1'b0;
      @(posedge sys_clk);
      e = expErr(error_select_a, r, sp);
      h = hit(m, e, l, u);
      rc(OFF_ERR_HI, e[15:8], "errorHigh");
      rc(OFF_ERR_LO, e[7:0], "errorLow");
      bus(OFF_STAT, 1'b0, 8'h00, q);
      chk("flags", 32'({$signed(e) > $signed(u), $signed(e) < $signed(l)}), 32'(q[6:5]));
      rc(OFF_IRQ_ST, {7'h0, h}, "irqStatus");
      chk("irq", 32'(h & msk), 32'(irq));
      wr(OFF_IRQ_ST, 8'h01);
      rc(OFF_IRQ_ST, 8'h00, "irqCleared");
    end
    // Codes 28, 30 and 31 break the software rule on purpose, to see that they stay quiet.
    for (c = 0; c < 32; c++) begin
      if (c inside {26, 27, 29}) continue;
      wr(OFF_ACT, c[7:0]);
      s0 = starts;
      trigIn <= (c == 0 || c > 25) ? '1 : 25'h1 << (c - 1);
      repeat (10) @(posedge sys_clk);
      trigIn <= '0;
      repeat (6) @(posedge sys_clk);
      chk("hwStarts", 32'(c >= 1 && c <= 25), 32'(starts - s0));
    end
    foreach (swCode[k]) begin
      wr(OFF_ACT, {3'h0, swCode[k]});
      for (j = 0; j < 3; j++) begin
        s0 = starts;
        if (j == 2) wr(OFF_CHAN, 8'h05);
        else bus(j ? OFF_RES_HI : OFF_ERR_HI, 1'b0, 8'h00, q);
        repeat (3) @(posedge sys_clk);
        chk("swStarts", 32'(j == k), 32'(starts - s0));
      end
    end
    pumpRequest <= 1'b1;
    pumpReadyIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("pumpOff", 32'h0, 32'(pumpOn));
    rc(OFF_CP, 8'h00, "readyDisabled");
    wr(OFF_CP, 8'hFF);
    repeat (4) @(posedge sys_clk);
    chk("pumpOn", 32'h1, 32'(pumpOn));
    rc(OFF_CP, 8'h81, "readyEnabled");
    rc(OFF_IRQ_ST, 8'h02, "readyEvent");
    pumpRequest <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("pumpIdle", 32'h0, 32'(pumpOn));
    pumpRequest <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rc(OFF_CP, 8'h00, "pumpAfterReset");
    rc(OFF_LTH_HI, 8'h00, "lowerAfterReset");
    end_of_test;
  end
endmodule : test_att_top
